/* File: pkg/read_config_pkg.sv */
package read_config_pkg;

  // instruction codes
  localparam logic [7:0] OP_WR_VOLATILE   = 8'h81;
  localparam logic [7:0] OP_RD_VOLATILE   = 8'h85;
  localparam logic [7:0] OP_WR_ENHANCED   = 8'h61;
  localparam logic [7:0] OP_RD_ENHANCED   = 8'h65;
  localparam logic [7:0] OP_FAST_READ     = 8'h0b;
  localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3b;
  localparam logic [7:0] OP_DUAL_IO_READ  = 8'hbb;
  localparam logic [7:0] OP_QUAD_OUT_READ = 8'h6b;
  localparam logic [7:0] OP_QUAD_IO_READ  = 8'heb;
  localparam logic [7:0] OP_OTP_READ      = 8'h4b;

  // volatile register layout
  localparam int         VRS_DUMMY_MSB   = 7;
  localparam int         VRS_DUMMY_LSB   = 4;
  localparam int         VRS_XIP_BIT     = 3;
  localparam int         VRS_RSV_BIT     = 2;
  localparam logic [3:0] VRS_POR_LOW     = 4'hb;
  localparam logic [3:0] DUMMY_ZERO_CODE = 4'h0;
  localparam logic [3:0] DUMMY_MAX_CODE  = 4'hf;

  // wrap field codes
  localparam logic [1:0] WRAP_16     = 2'h0;
  localparam logic [1:0] WRAP_32     = 2'h1;
  localparam logic [1:0] WRAP_64     = 2'h2;
  localparam logic [1:0] WRAP_LINEAR = 2'h3;

  // persistent register fields used at power-on
  localparam int NV_DUMMY_MSB = 15;
  localparam int NV_DUMMY_LSB = 12;
  localparam int NV_HOLD_BIT  = 4;
  localparam int NV_QUAD_BIT  = 3;
  localparam int NV_DUAL_BIT  = 2;

  // enhanced register layout
  localparam int         ENH_QUAD_BIT = 7;
  localparam int         ENH_DUAL_BIT = 6;
  localparam int         ENH_RSV_BIT  = 5;
  localparam logic [3:0] ENH_POR_LOW  = 4'hf;

  localparam logic [1:0] PROTO_EXT  = 2'h0;
  localparam logic [1:0] PROTO_DUAL = 2'h1;
  localparam logic [1:0] PROTO_QUAD = 2'h2;

  localparam logic [4:0] CMD_BITS  = 5'h08;
  localparam logic [4:0] ADDR_BITS = 5'h18;
  localparam logic [4:0] BITS_CAP  = 5'h10;
  localparam logic [1:0] INIT_LOAD = 2'h2;
  localparam logic [1:0] INIT_DONE = 2'h3;

endpackage : read_config_pkg

/* File: src/volatile_read_config.sv */
// Function
// RULE_01: completed volatile write loads register, replacing power-on configuration
// RULE_02: bits 7..4 set dummy clocks after fast reads, 1 to 15
// RULE_03: dummy code 0000 acts as 1111; other codes give their value
// RULE_04: host picks enough dummy clocks for its clock rate
// RULE_05: dummy count applies to all fast reads and the otp read
// RULE_06: bit 3 low arms execute-in-place; default high leaves it off
// RULE_07: when armed, data line 0 at first dummy clock is sampled
// RULE_08: basic variant ignores the arm bit; always armed
// RULE_09: wrap code 00 wraps inside aligned 16-byte block
// RULE_10: wrap code 01 wraps inside aligned 32-byte block
// RULE_11: wrap code 10 wraps inside aligned 64-byte block
// RULE_12: wrap code 11 reads sequentially without boundary
// RULE_13: address increments from start, returns to block start, repeats
// RULE_14: completed enhanced write loads enhanced register over power-on values
// RULE_15: volatile bit 2 is reserved, written 0, always reads 0
// RULE_16: dummy counter counts exactly the programmed clocks before data
// RULE_17: power-on dummy count comes from persistent bits 15..12
// RULE_18: enhanced bits 7/6 low pick quad/dual; both low means quad
`timescale 1ns/1ps
`default_nettype none
module volatile_read_config
  import read_config_pkg::*;
#(
  parameter int ADDR_W = 24
) (
  input  wire logic              i_ref_clk,
  input  wire logic              i_arst_n,
  input  wire logic              i_sclk,
  input  wire logic              i_cs_n,
  input  wire logic [3:0]        i_dq,
  input  wire logic [15:0]       i_persistent_boot_settings,
  input  wire logic              i_basic_xip_variant,
  output logic                   o_dq1,
  output logic                   o_dq1_oe,
  output logic [7:0]             o_volatile_read_settings,
  output logic [7:0]             o_enhanced_volatile_settings,
  output logic [1:0]             o_protocol,
  output logic                   o_xip_armed,
  output logic                   o_xip_confirm,
  output logic                   o_data_phase,
  output logic                   o_byte_strobe,
  output logic [ADDR_W-1:0]      o_byte_addr
);

  typedef enum logic [2:0] {
    ST_CMD     = 3'h0,
    ST_ADDR    = 3'h1,
    ST_DUMMY   = 3'h2,
    ST_DATA    = 3'h3,
    ST_REG_OUT = 3'h4,
    ST_REG_IN  = 3'h5,
    ST_SKIP    = 3'h6
  } link_state_t;

  typedef struct packed {
    logic              sclk_m;
    logic              sclk_s;
    logic              sclk_p;
    logic              cs_m;
    logic              cs_s;
    logic [3:0]        dq_m;
    logic [3:0]        dq_s;
    logic [15:0]       nv_m;
    logic [15:0]       nv_s;
    logic              basic_m;
    logic              basic_s;
    logic [1:0]        init;
    logic [7:0]        volatile_read_settings;
    logic [7:0]        enh;
    link_state_t       st;
    logic [7:0]        cmd;
    logic [23:0]       sh;
    logic [4:0]        bcnt;
    logic [3:0]        dcnt;
    logic [2:0]        lanes;
    logic              wr_done;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        oshift;
    logic              dq1;
    logic              dq1_oe;
    logic [1:0]        protocol;
    logic              xip_armed;
    logic              xip_confirm;
    logic              data_phase;
    logic              byte_strobe;
    logic [ADDR_W-1:0] byte_addr;
  } state_t;

  state_t q;
  state_t d;
  logic   rise;
  logic   fall;

  function automatic logic [3:0] dummy_clocks(input logic [3:0] code);
    dummy_clocks = (code == DUMMY_ZERO_CODE) ? DUMMY_MAX_CODE : code; // RULE_03
  endfunction : dummy_clocks

  function automatic logic [2:0] lane_count(input logic [1:0] proto);
    case (proto)
      PROTO_DUAL: lane_count = 3'h2;
      PROTO_QUAD: lane_count = 3'h4;
      default:    lane_count = 3'h1;
    endcase
  endfunction : lane_count

  function automatic logic is_fast_read(input logic [7:0] op);
    is_fast_read = (op == OP_FAST_READ) || (op == OP_DUAL_OUT_READ) ||
                   (op == OP_DUAL_IO_READ) || (op == OP_QUAD_OUT_READ) ||
                   (op == OP_QUAD_IO_READ) || (op == OP_OTP_READ); // RULE_05
  endfunction : is_fast_read

  function automatic logic [2:0] data_lanes(input logic [7:0] op,
                                            input logic [1:0] proto);
    if (proto != PROTO_EXT) begin
      data_lanes = lane_count(proto);
    end else if (op == OP_DUAL_OUT_READ || op == OP_DUAL_IO_READ) begin
      data_lanes = 3'h2;
    end else if (op == OP_QUAD_OUT_READ || op == OP_QUAD_IO_READ) begin
      data_lanes = 3'h4;
    end else begin
      data_lanes = 3'h1;
    end
  endfunction : data_lanes

  function automatic logic [23:0] shift_in(input logic [23:0] sh,
                                           input logic [3:0]  dq,
                                           input logic [2:0]  n);
    case (n)
      3'h2:    shift_in = {sh[21:0], dq[1:0]};
      3'h4:    shift_in = {sh[19:0], dq[3:0]};
      default: shift_in = {sh[22:0], dq[0]};
    endcase
  endfunction : shift_in

  function automatic logic [ADDR_W-1:0] wrap_mask(input logic [1:0] wrap);
    case (wrap)
      WRAP_16: wrap_mask = ADDR_W'(24'h00000f); // RULE_09
      WRAP_32: wrap_mask = ADDR_W'(24'h00001f); // RULE_10
      WRAP_64: wrap_mask = ADDR_W'(24'h00003f); // RULE_11
      default: wrap_mask = '0;
    endcase
  endfunction : wrap_mask

  function automatic logic [ADDR_W-1:0] next_addr(
      input logic [ADDR_W-1:0] a,
      input logic [1:0]        wrap);
    logic [ADDR_W-1:0] m;
    m = wrap_mask(wrap);
    if (wrap == WRAP_LINEAR) begin
      next_addr = a + ADDR_W'(1); // RULE_12
    end else begin
      next_addr = (a & ~m) | ((a + ADDR_W'(1)) & m); // RULE_13
    end
  endfunction : next_addr

  function automatic logic [1:0] proto_of(input logic [7:0] enh);
    if (!enh[ENH_QUAD_BIT]) begin
      proto_of = PROTO_QUAD; // RULE_18
    end else if (!enh[ENH_DUAL_BIT]) begin
      proto_of = PROTO_DUAL;
    end else begin
      proto_of = PROTO_EXT;
    end
  endfunction : proto_of

  assign rise = q.sclk_s & ~q.sclk_p;
  assign fall = ~q.sclk_s & q.sclk_p;

  always_comb begin
    logic [4:0] nb;
    nb = 5'(q.bcnt + {2'h0, q.lanes});
    d = q;
    d.sclk_m      = i_sclk;
    d.sclk_s      = q.sclk_m;
    d.sclk_p      = q.sclk_s;
    d.cs_m        = i_cs_n;
    d.cs_s        = q.cs_m;
    d.dq_m        = i_dq;
    d.dq_s        = q.dq_m;
    d.nv_m        = i_persistent_boot_settings;
    d.nv_s        = q.nv_m;
    d.basic_m     = i_basic_xip_variant;
    d.basic_s     = q.basic_m;
    d.byte_strobe = 1'b0;
    if (q.init != INIT_DONE) begin
      d.init = q.init + 2'h1;
      if (q.init == INIT_LOAD) begin
        d.volatile_read_settings = {q.nv_s[NV_DUMMY_MSB:NV_DUMMY_LSB], VRS_POR_LOW}; // RULE_17
        d.enh = {q.nv_s[NV_QUAD_BIT], q.nv_s[NV_DUAL_BIT], 1'b0,
                 q.nv_s[NV_HOLD_BIT], ENH_POR_LOW};
      end
    end
    if (q.cs_s) begin
      // load only on deselect after exactly one whole data byte
      if (q.st == ST_REG_IN && q.wr_done) begin
        if (q.cmd == OP_WR_VOLATILE) begin
          d.volatile_read_settings = {q.sh[7:3], 1'b0, q.sh[1:0]}; // RULE_01 RULE_15
        end else begin
          d.enh = {q.sh[7:6], 1'b0, q.sh[4:0]}; // RULE_14
        end
      end
      d.st      = ST_CMD;
      d.bcnt    = 5'h00;
      d.wr_done = 1'b0;
      d.dq1_oe  = 1'b0;
      d.lanes   = lane_count(q.protocol);
    end else if (rise) begin
      case (q.st)
        ST_CMD: begin
          d.sh   = shift_in(q.sh, q.dq_s, q.lanes);
          d.bcnt = nb;
          if (nb == CMD_BITS) begin
            d.cmd  = d.sh[7:0];
            d.bcnt = 5'h00;
            if (is_fast_read(d.sh[7:0])) begin
              d.st = ST_ADDR;
              if (d.sh[7:0] == OP_DUAL_IO_READ ||
                  d.sh[7:0] == OP_QUAD_IO_READ) begin
                d.lanes = data_lanes(d.sh[7:0], q.protocol);
              end
            end else if (d.sh[7:0] == OP_RD_VOLATILE) begin
              d.st     = ST_REG_OUT;
              d.oshift = q.volatile_read_settings;
            end else if (d.sh[7:0] == OP_RD_ENHANCED) begin
              d.st     = ST_REG_OUT;
              d.oshift = q.enh;
            end else if (d.sh[7:0] == OP_WR_VOLATILE ||
                         d.sh[7:0] == OP_WR_ENHANCED) begin
              d.st = ST_REG_IN;
            end else begin
              d.st = ST_SKIP;
            end
          end
        end
        ST_ADDR: begin
          d.sh   = shift_in(q.sh, q.dq_s, q.lanes);
          d.bcnt = nb;
          if (nb == ADDR_BITS) begin
            d.addr  = ADDR_W'(d.sh);
            d.bcnt  = 5'h00;
            d.dcnt  = 4'h0;
            d.st    = ST_DUMMY;
            d.lanes = data_lanes(q.cmd, q.protocol);
          end
        end
        ST_DUMMY: begin
          if (q.dcnt == 4'h0 && q.xip_armed) begin
            d.xip_confirm = q.dq_s[0]; // RULE_07
          end
          if (4'(q.dcnt + 4'h1) ==
              dummy_clocks(q.volatile_read_settings[VRS_DUMMY_MSB:VRS_DUMMY_LSB])) begin
            d.st          = ST_DATA; // RULE_02 RULE_16
            d.byte_addr   = q.addr;
            d.byte_strobe = 1'b1;
          end else begin
            d.dcnt = 4'(q.dcnt + 4'h1);
          end
        end
        ST_DATA: begin
          if (nb == CMD_BITS) begin
            d.bcnt        = 5'h00;
            d.addr        = next_addr(q.addr, q.volatile_read_settings[1:0]);
            d.byte_addr   = d.addr;
            d.byte_strobe = 1'b1;
          end else begin
            d.bcnt = nb;
          end
        end
        ST_REG_IN: begin
          d.sh      = shift_in(q.sh, q.dq_s, q.lanes);
          d.wr_done = (nb == CMD_BITS);
          if (q.bcnt < BITS_CAP) begin
            d.bcnt = nb;
          end
        end
        default: begin
          d.st = q.st;
        end
      endcase
    end else if (fall && q.st == ST_REG_OUT) begin
      d.dq1    = q.oshift[7];
      d.dq1_oe = 1'b1;
      d.oshift = {q.oshift[6:0], q.oshift[7]};
    end
    d.xip_armed  = ~d.volatile_read_settings[VRS_XIP_BIT] | q.basic_s; // RULE_06 RULE_08
    d.protocol   = proto_of(d.enh);
    d.data_phase = (d.st == ST_DATA);
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      q          <= '0;
      q.sclk_m   <= 1'b0;
      q.cs_m     <= 1'b1;
      q.cs_s     <= 1'b1;
      q.st       <= ST_CMD;
      q.volatile_read_settings      <= {DUMMY_MAX_CODE, VRS_POR_LOW};
      q.enh      <= 8'hdf;
      q.lanes    <= 3'h1;
      q.protocol <= PROTO_EXT;
    end else begin
      q <= d;
    end
  end

  assign o_dq1                        = q.dq1;
  assign o_dq1_oe                     = q.dq1_oe;
  assign o_volatile_read_settings     = q.volatile_read_settings;
  assign o_enhanced_volatile_settings = q.enh;
  assign o_protocol                   = q.protocol;
  assign o_xip_armed                  = q.xip_armed;
  assign o_xip_confirm                = q.xip_confirm;
  assign o_data_phase                 = q.data_phase;
  assign o_byte_strobe                = q.byte_strobe;
  assign o_byte_addr                  = q.byte_addr;

  // checker helper: rising link edges seen in the dummy phase
  logic [4:0] dummy_seen_q;
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dummy_seen_q <= 5'h00;
    end else if (q.st == ST_CMD) begin
      dummy_seen_q <= 5'h00;
    end else if (rise && q.st == ST_DUMMY && !q.cs_s) begin
      dummy_seen_q <= 5'(dummy_seen_q + 5'h01);
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);

  chk_vol_write_load: assert property ( // RULE_01
    (q.cs_s && q.st == ST_REG_IN && q.wr_done && q.cmd == OP_WR_VOLATILE)
    |=> (q.volatile_read_settings[7:3] == $past(q.sh[7:3]) && q.volatile_read_settings[1:0] == $past(q.sh[1:0])))
    else $error("volatile register not loaded by write");

  chk_enh_write_load: assert property ( // RULE_14
    (q.cs_s && q.st == ST_REG_IN && q.wr_done && q.cmd == OP_WR_ENHANCED)
    |=> (q.enh[7:6] == $past(q.sh[7:6]) && q.enh[4:0] == $past(q.sh[4:0])))
    else $error("enhanced register not loaded by write");

  chk_reserved_zero: assert property ( // RULE_15
    o_volatile_read_settings[VRS_RSV_BIT] == 1'b0)
    else $error("reserved volatile bit reads one");

  chk_dummy_count: assert property ( // RULE_16
    (q.st == ST_DATA && $past(q.st) == ST_DUMMY)
    |-> (dummy_seen_q ==
         {1'b0, dummy_clocks(q.volatile_read_settings[VRS_DUMMY_MSB:VRS_DUMMY_LSB])}))
    else $error("dummy phase length differs from programmed count");

  chk_wrap_block: assert property ( // RULE_09
    (o_byte_strobe && q.volatile_read_settings[1:0] != WRAP_LINEAR && $past(q.st) == ST_DATA)
    |-> (((o_byte_addr ^ $past(o_byte_addr)) & ~wrap_mask(q.volatile_read_settings[1:0]))
         == '0))
    else $error("wrapped read left its aligned block");

  chk_wrap_return: assert property ( // RULE_13
    (o_byte_strobe && q.volatile_read_settings[1:0] != WRAP_LINEAR && $past(q.st) == ST_DATA &&
     (($past(o_byte_addr) & wrap_mask(q.volatile_read_settings[1:0])) ==
      wrap_mask(q.volatile_read_settings[1:0])))
    |-> ((o_byte_addr & wrap_mask(q.volatile_read_settings[1:0])) == '0))
    else $error("wrapped read did not return to block start");

  chk_linear_step: assert property ( // RULE_12
    (o_byte_strobe && q.volatile_read_settings[1:0] == WRAP_LINEAR && $past(q.st) == ST_DATA)
    |-> (o_byte_addr == ADDR_W'($past(o_byte_addr) + ADDR_W'(1))))
    else $error("linear read did not step by one");

  chk_power_on_dummy: assert property ( // RULE_17
    (q.init == INIT_DONE && $past(q.init) == INIT_LOAD)
    |-> (q.volatile_read_settings[7:4] == $past(q.nv_s[NV_DUMMY_MSB:NV_DUMMY_LSB])))
    else $error("power-on dummy count not taken from persistent bits");

  chk_quad_wins: assert property ( // RULE_18
    !o_enhanced_volatile_settings[ENH_QUAD_BIT] |-> (o_protocol == PROTO_QUAD))
    else $error("quad select did not win");

  chk_xip_sample: assert property ( // RULE_07
    ($past(q.st) == ST_DUMMY && $past(q.dcnt) == 4'h0 && $past(rise) &&
     !$past(q.cs_s) && $past(o_xip_armed))
    |-> (o_xip_confirm == $past(q.dq_s[0])))
    else $error("first dummy data line value not captured");

  chk_basic_armed: assert property ( // RULE_08
    q.basic_s |=> o_xip_armed)
    else $error("basic variant not armed");

endmodule : volatile_read_config
`default_nettype wire

/* File: bench/spi_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input  wire logic       i_ref_clk,
  input  wire logic       i_dq1,
  output logic            o_sclk,
  output logic            o_cs_n,
  output logic [3:0]      o_dq
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_dq   = 4'h5;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask : tick

  task automatic open_frame();
    @(posedge i_ref_clk) o_cs_n <= 1'b0;
    tick(4);
  endtask : open_frame

  // released lines flip so no stale value lingers
  task automatic close_frame();
    tick(2);
    @(posedge i_ref_clk) begin
      o_cs_n <= 1'b1;
      o_dq   <= ~o_dq;
    end
    tick(6);
  endtask : close_frame

  // mode 0, msb first; line 1 is taken just before each fall
  task automatic shift(input logic [31:0] v, input int nbits,
                       input int lanes, output logic [31:0] rd);
    logic [3:0] d;
    int         pos;
    rd  = '0;
    pos = nbits - 1;
    while (pos >= 0) begin
      d = ~o_dq;
      for (int j = 0; j < lanes; j++)
        d[j] = v[pos - lanes + 1 + j];
      @(posedge i_ref_clk) o_dq <= d;
      tick(3);
      @(posedge i_ref_clk) o_sclk <= 1'b1;
      tick(3);
      @(posedge i_ref_clk) begin
        rd = {rd[30:0], i_dq1};
        o_sclk <= 1'b0;
      end
      pos = pos - lanes;
    end
  endtask : shift
endmodule : spi_host_model
`default_nettype wire

/* File: bench/test_volatile_read_config.sv */
`timescale 1ns/1ps
`default_nettype none
module test_volatile_read_config
  import read_config_pkg::*;
;
  typedef struct {
    logic [7:0]  wr;
    logic [7:0]  exp;
    int          nd;
    logic [7:0]  op;
    int          al;
    int          dl;
    logic [23:0] start;
  } row_t;

  logic        ref_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [15:0] nv_bits = 16'h500c;
  logic        basic_variant = 1'b0;
  logic        sclk, cs_n, dq1, dq1_oe, armed, confirm;
  logic        data_phase, strobe;
  logic [3:0]  dq;
  logic [7:0]  vrs, enh;
  logic [1:0]  proto;
  logic [23:0] byte_addr;
  int          bad_count = 0;
  int          num_checks = 0;
  row_t        rows [6];
  logic [7:0]  enh_wr [4] = '{8'hff, 8'h7f, 8'hbf, 8'h3f};
  logic [1:0]  enh_pr [4] = '{PROTO_EXT, PROTO_QUAD, PROTO_DUAL, PROTO_QUAD};

  always #20 ref_clk = ~ref_clk;

  spi_host_model i_host (.i_ref_clk(ref_clk), .i_dq1(dq1), .o_sclk(sclk),
                         .o_cs_n(cs_n), .o_dq(dq));

  volatile_read_config i_dut (
    .i_ref_clk(ref_clk), .i_arst_n(arst_n), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_dq(dq), .i_persistent_boot_settings(nv_bits),
    .i_basic_xip_variant(basic_variant), .o_dq1(dq1), .o_dq1_oe(dq1_oe),
    .o_volatile_read_settings(vrs), .o_enhanced_volatile_settings(enh),
    .o_protocol(proto), .o_xip_armed(armed), .o_xip_confirm(confirm),
    .o_data_phase(data_phase), .o_byte_strobe(strobe),
    .o_byte_addr(byte_addr));

  task automatic cmp_bit(input string name, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s exp %h got %h", name, e, g);
    end
  endtask : cmp_bit

  task automatic cmp_byte(input string name, input logic [7:0] e,
                          input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s exp %h got %h", name, e, g);
    end
  endtask : cmp_byte

  task automatic cmp_addr(input string name, input logic [23:0] e,
                          input logic [23:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s exp %h got %h", name, e, g);
    end
  endtask : cmp_addr

  task automatic wrap_up();
    if (bad_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  function automatic logic [23:0] next_addr(input logic [23:0] a,
                                            input logic [1:0]  w);
    logic [23:0] m;
    m = (w == 2'h3) ? 24'hffffff : ((24'h10 << w) - 24'h1);
    return (a & ~m) | ((a + 24'h1) & m);
  endfunction : next_addr

  task automatic wr_reg(input logic [7:0] op, input logic [7:0] v,
                        input int nbits, input int lanes);
    logic [31:0] rd;
    i_host.open_frame();
    i_host.shift({24'h0, op}, 8, lanes, rd);
    i_host.shift({24'h0, v}, nbits, lanes, rd);
    i_host.close_frame();
  endtask : wr_reg

  task automatic rd_check(input logic [7:0] op, input logic [7:0] e);
    logic [31:0] rd;
    i_host.open_frame();
    i_host.shift({24'h0, op}, 8, 1, rd);
    i_host.shift(32'h0, 8, 1, rd);
    cmp_bit("drive enable", 1'b1, dq1_oe);
    cmp_byte("read back", e, rd[7:0]);
    i_host.close_frame();
    cmp_bit("drive release", 1'b0, dq1_oe);
  endtask : rd_check

  initial begin
    #1ms;
    bad_count++;
    wrap_up();
  end

  initial begin
    row_t        rw;
    logic [31:0] rd;
    logic [23:0] a;
    int          lanes;
    rows = '{'{8'h00, 8'h00, 15, OP_FAST_READ, 1, 1, 24'h00001f},
             '{8'h15, 8'h11, 1, OP_DUAL_OUT_READ, 1, 2, 24'h00003f},
             '{8'he2, 8'he2, 14, OP_DUAL_IO_READ, 2, 2, 24'h12347f},
             '{8'h3b, 8'h3b, 3, OP_QUAD_OUT_READ, 1, 4, 24'h0000ff},
             '{8'h73, 8'h73, 7, OP_QUAD_IO_READ, 4, 4, 24'hfffffe},
             '{8'hf4, 8'hf0, 15, OP_OTP_READ, 1, 1, 24'h000005}};
    repeat (4) @(posedge ref_clk);
    cmp_byte("reset settings", 8'hfb, vrs);
    cmp_byte("reset enhanced", 8'hdf, enh);
    @(posedge ref_clk) arst_n <= 1'b1;
    i_host.tick(6);
    cmp_byte("boot settings", {nv_bits[15:12], 4'hb}, vrs);
    cmp_byte("boot enhanced", 8'hcf, enh);
    rd_check(OP_RD_VOLATILE, 8'h5b);
    for (int r = 0; r < 6; r++) begin
      rw = rows[r];
      wr_reg(OP_WR_VOLATILE, rw.wr, 8, 1);
      cmp_byte("settings", rw.exp, vrs);
      cmp_bit("armed", ~rw.exp[VRS_XIP_BIT], armed);
      i_host.open_frame();
      i_host.shift({24'h0, rw.op}, 8, 1, rd);
      i_host.shift({8'h0, rw.start}, 24, rw.al, rd);
      // first dummy clock carries all lines high
      i_host.shift(32'hf, 4, 4, rd);
      i_host.tick(2);
      if (rw.nd > 1) begin
        i_host.shift(32'h0, rw.nd - 2, 1, rd);
        i_host.tick(2);
        cmp_bit("early data", 1'b0, data_phase);
        i_host.shift(32'h0, 1, 1, rd);
        i_host.tick(2);
      end
      if (!rw.exp[VRS_XIP_BIT])
        cmp_bit("confirm", 1'b1, confirm);
      cmp_bit("data phase", 1'b1, data_phase);
      a = rw.start;
      cmp_addr("first addr", a, byte_addr);
      for (int k = 0; k < 2; k++) begin
        i_host.shift(32'h0, 8, rw.dl, rd);
        i_host.tick(2);
        a = next_addr(a, rw.exp[1:0]);
        cmp_addr("next addr", a, byte_addr);
      end
      i_host.close_frame();
      cmp_bit("data end", 1'b0, data_phase);
    end
    wr_reg(OP_WR_VOLATILE, 8'h12, 7, 1);
    cmp_byte("short write", 8'hf0, vrs);
    wr_reg(OP_WR_VOLATILE, 8'hfb, 8, 1);
    cmp_bit("not armed", 1'b0, armed);
    @(posedge ref_clk) basic_variant <= 1'b1;
    i_host.tick(6);
    cmp_bit("basic armed", 1'b1, armed);
    @(posedge ref_clk) basic_variant <= 1'b0;
    lanes = 1;
    for (int e = 0; e < 4; e++) begin
      wr_reg(OP_WR_ENHANCED, enh_wr[e], 8, lanes);
      cmp_byte("enhanced", enh_wr[e] & 8'hdf, enh);
      cmp_byte("protocol", {6'h0, enh_pr[e]}, {6'h0, proto});
      lanes = (enh_pr[e] == PROTO_QUAD) ? 4 :
              (enh_pr[e] == PROTO_DUAL) ? 2 : 1;
    end
    wr_reg(OP_WR_VOLATILE, 8'h21, 8, lanes);
    cmp_byte("quad write", 8'h21, vrs);
    @(posedge ref_clk) begin
      arst_n  <= 1'b0;
      nv_bits <= 16'ha01c;
    end
    i_host.tick(2);
    cmp_byte("mid reset", 8'hfb, vrs);
    @(posedge ref_clk) arst_n <= 1'b1;
    i_host.tick(6);
    cmp_byte("reboot", 8'hab, vrs);
    cmp_byte("reboot enhanced", 8'hdf, enh);
    cmp_byte("reboot proto", {6'h0, PROTO_EXT}, {6'h0, proto});
    cmp_bit("reboot armed", 1'b0, armed);
    rd_check(OP_RD_ENHANCED, 8'hdf);
    wrap_up();
  end
endmodule : test_volatile_read_config
`default_nettype wire
